// ==== pcdemx_pkg.sv ====
// Package: register map, field positions and reset values for the pin groups
package pcdemx_pkg;
   // ----------------------------------------
   // Register indexes (printed offsets)
   // ----------------------------------------
   localparam logic [8:0] IDX_PIN_DATA_C = 9'h007;
   localparam logic [8:0] IDX_PIN_DATA_D = 9'h008;
   localparam logic [8:0] IDX_PIN_DATA_E = 9'h009;
   localparam logic [8:0] IDX_DIR_C = 9'h087;
   localparam logic [8:0] IDX_DIR_D = 9'h088;
   localparam logic [8:0] IDX_DIR_E = 9'h089;
   localparam logic [8:0] IDX_LCD_SEL = 9'h10D;
   localparam logic [8:0] IDX_PERIPH = 9'h1F0;
   // Byte address width on the bus
   localparam int ADDR_W = 12;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [5:0] RST_DIR_C = 6'h3F;
   localparam logic [7:0] RST_DIR_D = 8'hFF;
   localparam logic [7:0] RST_DIR_E = 8'hFF;
   localparam logic [7:0] RST_LCD_SEL = 8'hFF;
   localparam logic [7:0] RST_PERIPH = 8'h00;
   // ----------------------------------------
   // Segment-select field positions
   // ----------------------------------------
   localparam int SEL_D_LOW = 0;
   localparam int SEL_E_LOW = 1;
   localparam int SEL_E_HIGH = 2;
   localparam int SEL_E7_G7 = 6;
   localparam int SEL_D_HIGH = 7;
   // Peripheral enable field positions
   localparam int PER_TIMER_OSC = 0;
   localparam int PER_CCP = 1;
   localparam int PER_SSP = 2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== pcdemx_port.sv ====
// Pin groups C, D and E with peripheral and LCD multiplexing, AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Group C: six bidirectional pins, bits 5:0
// - Each group C pin has own direction
// - Direction one tristates, zero drives latch
// - Enabled peripheral forces pin direction
// - Group C bits 7:6 read zero
// - Reset: direction ones, group C latch kept, group D latch cleared
// - Pins 0,1 shared with timer oscillator
// - Pin 2 shared with capture/compare/PWM
// - Pins 3..5 shared with serial port
// - Group D pins 0..4 I/O or segments
// - Group D pins 5..7 input only
// - Group D 5..7 segments 29..31 or commons
// - Group D 0..4 segments 00..04
// - Group D direction only pins 0..4 digital
// - Segment selects reset to ones
// - Segment select overrides direction bit
// - Group E never drives digital output
// - Group E maps segments 05..11, 27
module pcdemx_port
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   // AXI4-Lite slave
   input wire logic [pcdemx_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pcdemx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Group C pins
   input wire logic [5:0] pin_c_in,
   output logic [5:0] pin_c_out,
   output logic [5:0] pin_c_oe,
   // Group C peripheral overrides: output value, force-output, force-input
   input wire logic [5:0] periph_c_out,
   input wire logic [5:0] periph_c_force_out,
   input wire logic [5:0] periph_c_force_in,
   output logic [5:0] periph_c_in,
   // Group D pins
   input wire logic [7:0] pin_d_in,
   output logic [4:0] pin_d_out,
   output logic [4:0] pin_d_oe,
   // Group E pins
   input wire logic [7:0] pin_e_in,
   // LCD ownership to the LCD driver, per pin
   output logic [7:0] lcd_own_d,
   output logic [7:0] lcd_own_e,
   output logic lcd_own_g7
);
   import pcdemx_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [21:0] sync1_ff; // First stage
   logic [21:0] sync2_ff; // Second stage
   logic [5:0] samp_c; // Sampled group C
   logic [7:0] samp_d; // Sampled group D
   logic [7:0] samp_e; // Sampled group E

   // Pins change with no relation to the clock, so only the
   // second stage is read; the enable freezes both stages and
   // a pin edge met while frozen shows two enabled edges later
   // Two flops on every pin input
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else if (clk_en)
      begin
         sync1_ff <= {pin_e_in, pin_d_in, pin_c_in};
         sync2_ff <= sync1_ff;
      end
   end
   assign samp_c = sync2_ff[5:0];
   assign samp_d = sync2_ff[13:6];
   assign samp_e = sync2_ff[21:14];
   // Peripherals see the sampled group C level
   assign periph_c_in = samp_c;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [5:0] latch_c_ff; // Group C output latch
   logic [4:0] latch_d_ff; // Group D output latch
   logic [5:0] dir_c_ff; // Group C direction
   logic [7:0] dir_d_ff; // Group D direction
   logic [7:0] dir_e_ff; // Group E direction, no effect
   logic [7:0] lcd_sel_ff; // Segment select
   logic [7:0] periph_en_ff; // Peripheral enables
   logic wr_fire; // Write taken this cycle
   logic [8:0] wr_idx; // Write register index
   logic [7:0] wr_byte; // Write data, lane 0

   // A lone address or lone data waits with ready low
   // until its partner arrives, so both land in one edge
   // Write address and data accepted together
   assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && clk_en;
   assign wr_idx = s_axi_awaddr[10:2];
   assign wr_byte = s_axi_wdata[7:0];

   // Group C latch: no reset, keeps value over any reset
   // Unknown after power-up until software writes it
   // Six pins, bits 5:0
   always_ff @(posedge clock)
   begin
      if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_PIN_DATA_C)
      begin
         latch_c_ff <= wr_byte[5:0];
      end
   end

   // Group D latch
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         latch_d_ff <= '0;
      end
      else if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_PIN_DATA_D)
      begin
         latch_d_ff <= wr_byte[4:0];
      end
   end

   // Group C direction, a one makes an input
   // Direction resets to inputs
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         dir_c_ff <= RST_DIR_C;
      end
      else if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_DIR_C)
      begin
         // Bits 7:6 have no storage
         dir_c_ff <= wr_byte[5:0];
      end
   end

   // Group D direction, only bits 4:0 reach a driver
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         dir_d_ff <= RST_DIR_D;
      end
      else if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_DIR_D)
      begin
         dir_d_ff <= wr_byte;
      end
   end

   // Group E direction, stored for software only
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         dir_e_ff <= RST_DIR_E;
      end
      else if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_DIR_E)
      begin
         dir_e_ff <= wr_byte;
      end
   end

   // Segment select, a one hands pins to the LCD
   // Selects reset to LCD
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         lcd_sel_ff <= RST_LCD_SEL;
      end
      else if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_LCD_SEL)
      begin
         lcd_sel_ff <= wr_byte;
      end
   end

   // Peripheral enables, all off after reset
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         periph_en_ff <= RST_PERIPH;
      end
      else if (wr_fire && s_axi_wstrb[0] && wr_idx == IDX_PERIPH)
      begin
         periph_en_ff <= wr_byte;
      end
   end

   // ----------------------------------------
   // Group C pin mux
   // ----------------------------------------
   logic [5:0] c_owner; // Peripheral enabled per pin
   logic [5:0] eff_dir_c; // Effective direction, 1 = input

   assign c_owner[1:0] = {2{periph_en_ff[PER_TIMER_OSC]}};
   assign c_owner[2] = periph_en_ff[PER_CCP];
   assign c_owner[5:3] = {3{periph_en_ff[PER_SSP]}};

   // Force-out wins when a peripheral asks for both
   // Per-pin direction and value select
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_pin_c
         always_comb
         begin
            if (c_owner[gi] && periph_c_force_out[gi])
            begin
               eff_dir_c[gi] = 1'b0;
            end
            else if (c_owner[gi] && periph_c_force_in[gi])
            begin
               eff_dir_c[gi] = 1'b1;
            end
            else
            begin
               eff_dir_c[gi] = dir_c_ff[gi];
            end
         end
         assign pin_c_oe[gi] = !eff_dir_c[gi];
         assign pin_c_out[gi] = (c_owner[gi] && periph_c_force_out[gi]) ? periph_c_out[gi] : latch_c_ff[gi];
      end
   endgenerate

   // ----------------------------------------
   // Group D and E LCD ownership
   // ----------------------------------------
   // One select bit per half
   // High half to segs 29..31 or commons
   assign lcd_own_d = {{3{lcd_sel_ff[SEL_D_HIGH]}}, {5{lcd_sel_ff[SEL_D_LOW]}}};
   // Group E freed by three bits
   assign lcd_own_e = {lcd_sel_ff[SEL_E7_G7], {2{lcd_sel_ff[SEL_E_HIGH]}}, {5{lcd_sel_ff[SEL_E_LOW]}}};
   // Group G pin 7 shares its select bit with group E pin 7
   assign lcd_own_g7 = lcd_sel_ff[SEL_E7_G7];

   // An owned pin never drives, whatever its direction bit
   // Select overrides direction
   // Direction only for digital pins 0..4
   assign pin_d_oe = ~dir_d_ff[4:0] & ~lcd_own_d[4:0];
   assign pin_d_out = latch_d_ff;
   // Pins 5..7 and group E have no output drivers

   // ----------------------------------------
   // AXI write response
   // ----------------------------------------
   logic wr_hit; // Write index mapped

   assign wr_hit = (wr_idx == IDX_PIN_DATA_C) || (wr_idx == IDX_PIN_DATA_D) || (wr_idx == IDX_PIN_DATA_E) ||
                   (wr_idx == IDX_DIR_C) || (wr_idx == IDX_DIR_D) || (wr_idx == IDX_DIR_E) ||
                   (wr_idx == IDX_LCD_SEL) || (wr_idx == IDX_PERIPH);
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;

   // Hazard: the response only retires while enabled, so a
   // master must not take it while the enable is low
   // Response one cycle after acceptance
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // AXI read
   // ----------------------------------------
   logic rd_fire; // Read taken this cycle
   logic [8:0] rd_idx; // Read register index
   logic [7:0] rd_byte; // Selected read value
   logic rd_hit; // Read index mapped

   assign rd_fire = s_axi_arvalid && !s_axi_rvalid && clk_en;
   assign rd_idx = s_axi_araddr[10:2];
   assign s_axi_arready = rd_fire;

   // Unmapped indexes read zero with an error response
   // Read mux
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (rd_idx)
         IDX_PIN_DATA_C: rd_byte = {2'h0, samp_c};
         IDX_PIN_DATA_D: rd_byte = samp_d;
         IDX_PIN_DATA_E: rd_byte = samp_e;
         // Stored direction bits, not the overridden ones
         IDX_DIR_C: rd_byte = {2'h0, dir_c_ff};
         IDX_DIR_D: rd_byte = dir_d_ff;
         IDX_DIR_E: rd_byte = dir_e_ff;
         IDX_LCD_SEL: rd_byte = lcd_sel_ff;
         IDX_PERIPH: rd_byte = periph_en_ff;
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read data registered one cycle after acceptance
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (rd_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // pcdemx_port
`default_nettype wire

// ==== pcdemx_port_properties.sv ====
// Checker of bus answers and pin ownership for the pin group block
`timescale 1ns/1ns
`default_nettype none
module pcdemx_port_checker
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [5:0] pin_c_oe,
   input wire logic [4:0] pin_d_oe,
   input wire logic [7:0] lcd_own_d,
   input wire logic [7:0] lcd_own_e,
   input wire logic lcd_own_g7
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (!resetn);
   AST_RST_OWN: assert property (
      $rose(resetn) |-> lcd_own_d == 8'hFF && lcd_own_e == 8'hFF && pin_c_oe == 6'h00)
      else $error("ownership or drive not at reset value");
   AST_WR_ANSWER: assert property (
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && clk_en |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   AST_RD_ANSWER: assert property (
      s_axi_arvalid && !s_axi_rvalid && clk_en |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("read late or upper bits set");
   AST_D_SETS: assert property (
      lcd_own_d[4:0] == {5{lcd_own_d[0]}} && lcd_own_d[7:5] == {3{lcd_own_d[7]}})
      else $error("group D halves not owned as sets");
   AST_D_OWN_OE: assert property (
      (pin_d_oe & lcd_own_d[4:0]) == 5'h00)
      else $error("owned group D pin driven");
   AST_E_SETS: assert property (
      lcd_own_e[4:0] == {5{lcd_own_e[0]}} && lcd_own_e[6:5] == {2{lcd_own_e[5]}})
      else $error("group E ownership not in sets");
   AST_G7_E7: assert property (
      lcd_own_g7 == lcd_own_e[7])
      else $error("pin E7 and G7 ownership differ");
   AST_OWN_WRITE: assert property (
      $changed(lcd_own_d) || $changed(lcd_own_e) |-> $past(s_axi_awvalid) && $past(s_axi_wvalid))
      else $error("ownership changed without a write");
endmodule // pcdemx_port_checker
bind pcdemx_port pcdemx_port_checker i_pcdemx_port_checker (.clock(clock), .resetn(resetn), .clk_en(clk_en),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .pin_c_oe(pin_c_oe), .pin_d_oe(pin_d_oe), .lcd_own_d(lcd_own_d), .lcd_own_e(lcd_own_e),
   .lcd_own_g7(lcd_own_g7));
`default_nettype wire

// ==== pcdemx_pins_model.sv ====
// Pins outside the block: driven pins read back, others show outside levels
`timescale 1ns/1ns
`default_nettype none
module pcdemx_pins_model
(
   input wire logic [5:0] pin_c_out,
   input wire logic [5:0] pin_c_oe,
   input wire logic [4:0] pin_d_out,
   input wire logic [4:0] pin_d_oe,
   input wire logic [5:0] ext_c,
   input wire logic [7:0] ext_d,
   output logic [5:0] pin_c_in,
   output logic [7:0] pin_d_in
);
   // Driven pin wins over outside level
   assign pin_c_in = (pin_c_out & pin_c_oe) | (ext_c & ~pin_c_oe);
   assign pin_d_in = {ext_d[7:5], (pin_d_out & pin_d_oe) | (ext_d[4:0] & ~pin_d_oe)};
endmodule // pcdemx_pins_model
`default_nettype wire

// ==== pcdemx_port_tb.sv ====
// Testbench of the pin group block
`timescale 1ns/1ns
`default_nettype none
module pcdemx_port_tb;
   import pcdemx_pkg::*;
   logic clock, resetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lcd_own_g7;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [5:0] pin_c_in, pin_c_out, pin_c_oe, periph_c_out, periph_c_force_out, periph_c_force_in, ext_c;
   logic [7:0] pin_d_in, pin_e_in, lcd_own_d, lcd_own_e, ext_d;
   logic [4:0] pin_d_out, pin_d_oe;
   logic [5:0] periph_c_in;
   int mismatches, tests_run, i;
   localparam logic [7:0] sel_tab [5] = '{8'h01, 8'h80, 8'h02, 8'h04, 8'h40};
   localparam logic [31:0] own_tab [5] = '{32'h1F, 32'hE0, 32'h1F00, 32'h6000, 32'h18000};
   pcdemx_port i_pcdemx_port (.clock(clock), .resetn(resetn), .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pin_c_in(pin_c_in), .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe),
      .periph_c_out(periph_c_out), .periph_c_force_out(periph_c_force_out),
      .periph_c_force_in(periph_c_force_in), .periph_c_in(periph_c_in), .pin_d_in(pin_d_in), .pin_d_out(pin_d_out),
      .pin_d_oe(pin_d_oe), .pin_e_in(pin_e_in), .lcd_own_d(lcd_own_d), .lcd_own_e(lcd_own_e),
      .lcd_own_g7(lcd_own_g7));
   pcdemx_pins_model i_pcdemx_pins_model (.pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe), .pin_d_out(pin_d_out),
      .pin_d_oe(pin_d_oe), .ext_c(ext_c), .ext_d(ext_d), .pin_c_in(pin_c_in), .pin_d_in(pin_d_in));
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask
   // Wait bound used up
   task automatic bound(input int n);
      if (n >= 60)
      begin
         mismatches++;
         test_done;
      end
   endtask
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      int n;
      // Let the last response retire before a new request
      @(posedge clock);
      s_axi_awaddr <= {1'b0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && n < 60);
      s_axi_bready <= 1'b0;
      bound(n);
      chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
   endtask
   task automatic rchk(input string what, input logic [8:0] idx, input logic [31:0] exp, input logic [1:0] er);
      int n;
      repeat (3) @(posedge clock);
      s_axi_araddr <= {1'b0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && n < 60);
      s_axi_rready <= 1'b0;
      bound(n);
      chk(what, exp, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask
   task automatic t_reset;
      chk("own_d", 32'hFF, 32'(lcd_own_d));
      chk("own_e", 32'hFF, 32'(lcd_own_e));
      rchk("lcd_sel", IDX_LCD_SEL, 32'hFF, RESP_OKAY);
      rchk("dir_c", IDX_DIR_C, 32'h3F, RESP_OKAY);
      rchk("dir_d", IDX_DIR_D, 32'hFF, RESP_OKAY);
      rchk("unmapped", 9'h1FF, 32'h0, RESP_SLVERR);
   endtask
   task automatic t_group_c;
      wr(IDX_DIR_C, 8'hFF);
      rchk("dir_c", IDX_DIR_C, 32'h3F, RESP_OKAY);
      rchk("in_c", IDX_PIN_DATA_C, 32'h15, RESP_OKAY);
      wr(IDX_PIN_DATA_C, 8'hEA);
      wr(IDX_DIR_C, 8'h0F);
      chk("c_oe", 32'h30, 32'(pin_c_oe));
      chk("c_out", 32'h20, 32'(pin_c_out & pin_c_oe));
      rchk("rd_c", IDX_PIN_DATA_C, 32'h25, RESP_OKAY);
   endtask
   task automatic t_periph;
      periph_c_out <= 6'h3F;
      periph_c_force_out <= 6'h01;
      periph_c_force_in <= 6'h10;
      wr(IDX_PERIPH, 8'h07);
      chk("force_oe", 32'h21, 32'(pin_c_oe));
      chk("force_out", 32'h21, 32'(pin_c_out & pin_c_oe));
      rchk("dir_kept", IDX_DIR_C, 32'h0F, RESP_OKAY);
      wr(IDX_PERIPH, 8'h00);
      chk("no_force", 32'h30, 32'(pin_c_oe));
   endtask
   task automatic t_lcd;
      wr(IDX_DIR_D, 8'h00);
      wr(IDX_PIN_DATA_D, 8'hFF);
      chk("d_owned", 32'h0, 32'(pin_d_oe));
      wr(IDX_LCD_SEL, 8'h00);
      chk("own_all", 32'h0, 32'({lcd_own_g7, lcd_own_e, lcd_own_d}));
      chk("d_oe", 32'h1F, 32'(pin_d_oe & pin_d_out));
      rchk("in_d", IDX_PIN_DATA_D, 32'hBF, RESP_OKAY);
      rchk("in_e", IDX_PIN_DATA_E, 32'h5A, RESP_OKAY);
      for (i = 0; i < 5; i++)
      begin
         wr(IDX_LCD_SEL, sel_tab[i]);
         chk("own_map", own_tab[i], 32'({lcd_own_g7, lcd_own_e, lcd_own_d}));
      end
   endtask
   task automatic t_rereset;
      resetn <= 1'b0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      wr(IDX_DIR_C, 8'h00);
      chk("latch_kept", 32'h2A, 32'(pin_c_out));
   endtask
   // Enable low freezes the pin samples seen by peripherals
   task automatic t_freeze;
      wr(IDX_DIR_C, 8'hFF);
      repeat (3) @(posedge clock);
      chk("c_in", 32'h15, 32'(periph_c_in));
      clk_en <= 1'b0;
      ext_c <= 6'h2A;
      repeat (4) @(posedge clock);
      clk_en <= 1'b1;
      repeat (2) @(posedge clock);
      chk("c_frozen", 32'h15, 32'(periph_c_in));
      @(posedge clock);
      chk("c_thawed", 32'h2A, 32'(periph_c_in));
   endtask
   initial
   begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {periph_c_out, periph_c_force_out, periph_c_force_in} = '0;
      clk_en = 1'b1;
      s_axi_wstrb = 4'hF;
      ext_c = 6'h15;
      ext_d = 8'hA3;
      pin_e_in = 8'h5A;
      mismatches = 0;
      tests_run = 0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      t_reset;
      t_group_c;
      t_periph;
      t_lcd;
      t_rereset;
      t_freeze;
      test_done;
   end
endmodule // pcdemx_port_tb
`default_nettype wire
